/* src/cpc_can_phy_control_register.sv */
// Transceiver control register with frame decode, feedback and a small
// transceiver mode sequencer, reached over an Avalon-MM slave.
// Assumes one 50 MHz clock, pins asynchronous to it, and a master that
// holds its request until waitrequest is low.
//
// Functional notes
// - Frames with select bits 11 address this control register.
// - Readback select one returns feedback register 1, zero the control.
// - Read-only flag set returns data without storing; clear also stores.
// - Keep-on bit holds the CAN supply regulator on while off-line.
// - Listen-only select makes the transceiver leave off-line for listen-only, not on-line.
// - Listen-only select clears itself on entering on-line or active.
// - Timeout select picks long or short; after wake-up extended.
// - Go off-line from on-line or listen-only only after idle bus for timeout.
// - Transmitter disable bit set turns the transmitter off.
// - Loopback routes transmit to receive only while transmitter disabled.
// - Active enable works only in normal or flash system mode.
// - Split enable drives the split pin; otherwise it floats.
// - Interface failure disables transmitter without touching disable bit.
// - Correct-level traffic received clears the interface failure.
// - Setting then clearing transmitter disable also clears the failure.
// - Stored settings are readable through the feedback word.
//
// Design decisions made here: register access over Avalon-MM and the register addresses.
module cpc_can_phy_control_register
  import cpc_pkg::*;
#(
  parameter int unsigned OFFLINE_SHORT_US = T_OFFLINE_SHORT_US,
  parameter int unsigned OFFLINE_LONG_US = T_OFFLINE_LONG_US,
  parameter int unsigned OFFLINE_EXT_US = T_OFFLINE_EXT_US
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire cpc_pkg::cpc_avs_req_t avs_req,
  output logic avs_waitrequest,
  output logic [31:0] avs_readdata,
  input wire logic [11:0] gp1_feedback,
  input wire cpc_pkg::cpc_pins_t pins,
  output cpc_pkg::cpc_xcvr_out_t xcvr
);
  import cpc_pkg::*;

  if (OFFLINE_SHORT_US == 0 || OFFLINE_LONG_US == 0 ||
      OFFLINE_EXT_US == 0 || OFFLINE_SHORT_US >= (1 << TMO_W) ||
      OFFLINE_LONG_US >= (1 << TMO_W) ||
      OFFLINE_EXT_US >= (1 << TMO_W)) begin : g_bad_timeout
    $error("Off-line timeouts must lie between 1 and 2**TMO_W-1 us.");
  end

  localparam logic [TMO_W-1:0] LIM_SHORT = TMO_W'(OFFLINE_SHORT_US);
  localparam logic [TMO_W-1:0] LIM_LONG = TMO_W'(OFFLINE_LONG_US);
  localparam logic [TMO_W-1:0] LIM_EXT = TMO_W'(OFFLINE_EXT_US);
  localparam int unsigned DIV_W = $clog2(TICK_CYC + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYC - 1);

  typedef struct packed {
    cpc_pins_t sync1;
    cpc_pins_t sync2;
    logic ack;
    logic [31:0] rdata;
    logic [11:0] ctrl;
    logic [15:0] resp;
    cpc_xcvr_t state;
    logic wake_ext;
    logic iface_fail;
    logic [DIV_W-1:0] div;
    logic [TMO_W-1:0] idle;
    logic rxd;
  } cpc_state_t;

  localparam cpc_state_t ST_RESET = '{
    sync1: '0,
    sync2: '0,
    ack: 1'b0,
    rdata: '0,
    ctrl: CTRL_RESET,
    resp: FRAME_RESET,
    state: XCVR_OFFLINE,
    wake_ext: 1'b0,
    iface_fail: 1'b0,
    div: '0,
    idle: '0,
    rxd: 1'b1
  };

  logic rst_meta_n;
  logic rst_n;
  cpc_state_t st_q;
  cpc_state_t st_d;

  // Reset is applied at once but released in step with the clock.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  function automatic logic [11:0] ctrl_feedback(input logic [11:0] c);
    ctrl_feedback = c;
  endfunction

  logic req;
  logic frame_ok;
  logic store;
  logic [15:0] wframe;
  logic [11:0] new_ctrl;
  logic tick;
  logic [TMO_W-1:0] limit;
  logic want_active;
  cpc_pins_t p;

  assign req = avs_req.read | avs_req.write;
  assign p = st_q.sync2;
  assign wframe = avs_req.writedata[15:0];

  always_comb begin
    st_d = st_q;
    st_d.sync1 = pins;
    st_d.sync2 = st_q.sync1;
    frame_ok = 1'b0;
    store = 1'b0;
    new_ctrl = st_q.ctrl;

    // One wait cycle per access: read data is registered on the first
    // edge so it stands at the edge where waitrequest is low.
    st_d.ack = req & ~st_q.ack;
    if (req && !st_q.ack) begin
      unique case (avs_req.address)
        OFS_FRAME: st_d.rdata = {16'h0000, st_q.resp};
        OFS_CONTROL: st_d.rdata = {20'h0_0000, ctrl_feedback(st_q.ctrl)};
        OFS_STATUS: st_d.rdata = {26'h000_0000, st_q.state,
                                  st_q.iface_fail, st_q.wake_ext,
                                  xcvr.tx_enable, xcvr.supply_on};
        default: st_d.rdata = 32'h0000_0000;
      endcase
    end

    // A frame is taken only whole, with both low byte lanes, at the edge
    // where the slave ends the wait.
    if (avs_req.write && st_q.ack && avs_req.address == OFS_FRAME &&
        avs_req.byteenable[1:0] == 2'b11) begin
      frame_ok = (wframe[POS_SEL_HI:POS_SEL_LO] == SEL_CAN_PHY);
    end
    if (frame_ok) begin
      // Feedback carries the contents held before this frame.
      st_d.resp = {SEL_CAN_PHY, wframe[POS_RRS], wframe[POS_RO],
                   wframe[POS_RRS] ? gp1_feedback
                                   : ctrl_feedback(st_q.ctrl)};
      store = ~wframe[POS_RO];
    end
    if (store) begin
      new_ctrl = wframe[11:0];
    end

    // Host release: disable bit written from one to zero.
    if (store && st_q.ctrl[POS_TXDIS] && !new_ctrl[POS_TXDIS]) begin
      st_d.iface_fail = 1'b0;
    end
    if (p.iface_good_rx) begin
      st_d.iface_fail = 1'b0;
    end
    // A new failure wins over any clear in the same cycle.
    if (p.iface_fail) begin
      st_d.iface_fail = 1'b1;
    end

    // Microsecond tick for the idle timer.
    tick = (st_q.div == DIV_LAST);
    st_d.div = tick ? '0 : st_q.div + 1'b1;

    limit = st_q.wake_ext ? LIM_EXT
          : (st_q.ctrl[POS_TMO] ? LIM_LONG : LIM_SHORT);
    want_active = new_ctrl[POS_ACTIVE] & p.sys_mode_ok;

    if (p.bus_active || st_q.state == XCVR_OFFLINE) begin
      st_d.idle = '0;
    end else if (tick && st_q.idle != limit) begin
      st_d.idle = st_q.idle + 1'b1;
    end

    unique case (st_q.state)
      XCVR_OFFLINE: begin
        if (p.wake) begin
          st_d.wake_ext = 1'b1;
        end
        if (p.bus_active || p.wake) begin
          st_d.state = new_ctrl[POS_LISTEN] ? XCVR_LISTEN
                                            : XCVR_ONLINE;
        end
      end
      XCVR_ONLINE, XCVR_LISTEN: begin
        if (want_active) begin
          st_d.state = XCVR_ACTIVE;
        end else if (st_q.idle >= limit) begin
          st_d.state = XCVR_OFFLINE;
          st_d.wake_ext = 1'b0;
        end else if (st_q.state == XCVR_LISTEN &&
                     !new_ctrl[POS_LISTEN]) begin
          st_d.state = XCVR_ONLINE;
        end
      end
      XCVR_ACTIVE: begin
        if (!want_active) begin
          st_d.state = XCVR_ONLINE;
        end
      end
    endcase

    // Entering on-line or active drops listen-only, even over a write.
    if (st_d.state != st_q.state &&
        (st_d.state == XCVR_ONLINE || st_d.state == XCVR_ACTIVE)) begin
      new_ctrl[POS_LISTEN] = 1'b0;
    end
    st_d.ctrl = new_ctrl;

    st_d.rxd = (st_q.ctrl[POS_LOOP] && st_q.ctrl[POS_TXDIS]) ? p.txd
                                                             : p.bus_rxd;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign avs_waitrequest = req & ~st_q.ack;
  assign avs_readdata = st_q.rdata;
  assign xcvr.supply_on = (st_q.state != XCVR_OFFLINE) |
                          st_q.ctrl[POS_KEEP];
  assign xcvr.tx_enable = (st_q.state == XCVR_ACTIVE) &
                          ~st_q.ctrl[POS_TXDIS] &
                          ~st_q.iface_fail;
  assign xcvr.rxd = st_q.rxd;
  assign xcvr.split_oe = st_q.ctrl[POS_SPLIT];
  assign xcvr.state = st_q.state;

endmodule

/* src/cpc_pkg.sv */
// Constants, register map, field positions and carrier types for the
// transceiver control register block.
// Assumes a single 50 MHz system clock and an Avalon-MM register master.
package cpc_pkg;

  // Clock rate and the one microsecond tick derived from it.
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned TICK_NS = 1000;
  localparam int unsigned TICK_CYC = (TICK_NS * (CLK_HZ / 1_000_000)) / 1000;

  // Default bus-idle timeouts in microseconds before going off-line.
  localparam int unsigned T_OFFLINE_SHORT_US = 1000;
  localparam int unsigned T_OFFLINE_LONG_US = 4000;
  localparam int unsigned T_OFFLINE_EXT_US = 16000;
  localparam int unsigned TMO_W = 20;

  // Avalon byte offsets of the software-visible words.
  localparam logic [3:0] OFS_FRAME = 4'h0;
  localparam logic [3:0] OFS_CONTROL = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;

  // Frame field positions.
  localparam int unsigned POS_SEL_HI = 15;
  localparam int unsigned POS_SEL_LO = 14;
  localparam int unsigned POS_RRS = 13;
  localparam int unsigned POS_RO = 12;

  // Control field positions within the 12 data bits.
  localparam int unsigned POS_KEEP = 11;
  localparam int unsigned POS_LISTEN = 10;
  localparam int unsigned POS_TMO = 9;
  localparam int unsigned POS_TXDIS = 8;
  localparam int unsigned POS_LOOP = 7;
  localparam int unsigned POS_ACTIVE = 6;
  localparam int unsigned POS_SPLIT = 5;

  localparam logic [1:0] SEL_CAN_PHY = 2'h3;
  localparam logic [11:0] CTRL_RESET = 12'h002;
  localparam logic [15:0] FRAME_RESET = 16'h0000;

  typedef enum logic [1:0] {
    XCVR_OFFLINE = 2'b00,
    XCVR_ONLINE = 2'b01,
    XCVR_LISTEN = 2'b10,
    XCVR_ACTIVE = 2'b11
  } cpc_xcvr_t;

  // Avalon-MM request from the master.
  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } cpc_avs_req_t;

  // Inputs from the transceiver core and system logic, all asynchronous.
  typedef struct packed {
    logic bus_active;
    logic wake;
    logic sys_mode_ok;
    logic iface_fail;
    logic iface_good_rx;
    logic txd;
    logic bus_rxd;
  } cpc_pins_t;

  // Outputs towards the transceiver core.
  typedef struct packed {
    logic supply_on;
    logic tx_enable;
    logic rxd;
    logic split_oe;
    cpc_xcvr_t state;
  } cpc_xcvr_out_t;

endpackage

/* verification/can_phy_control_register_tb.sv */
// Self-checking bench for the transceiver control register.
// Assumes the host model as bus master and small off-line timeouts.
`define CK(n, e, a) begin tests_run++; if ((a) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %h got %h", n, e, a); end end
module can_phy_control_register_tb;
  import cpc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] gp1 = 12'ha5c;
  cpc_pins_t pins = '0;
  cpc_avs_req_t req;
  logic wreq;
  logic [31:0] rdat;
  logic [31:0] q;
  cpc_xcvr_out_t x;
  int fails = 0;
  int tests_run = 0;
  initial forever #10 clk_sys = ~clk_sys;
  cpc_can_phy_control_register #(.OFFLINE_SHORT_US(2), .OFFLINE_LONG_US(3),
    .OFFLINE_EXT_US(5)) dut_u (.clk_sys, .rstn, .avs_req(req),
    .avs_waitrequest(wreq), .avs_readdata(rdat), .gp1_feedback(gp1), .pins,
    .xcvr(x));
  cpc_host_model host_u (.clk_sys, .avs_req(req), .avs_waitrequest(wreq),
    .avs_readdata(rdat));
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string n);
    host_u.xfer(1'b0, a, 32'h0000_0000, q);
    `CK(n, e, q)
  endtask
  // One spare edge lets the stored frame settle before anyone looks.
  task automatic fr(input logic readback_source_select, input logic ro, input logic [6:0] c);
    host_u.frame(readback_source_select, ro, c, q);
    @(posedge clk_sys);
  endtask
  task automatic wst(input cpc_xcvr_t s);
    for (int i = 0; i < 3000 && x.state !== s; i++) @(posedge clk_sys);
  endtask
  task automatic settle;
    repeat (5) @(posedge clk_sys);
  endtask
  task automatic t_reset;
    rd(OFS_CONTROL, {20'h0_0000, CTRL_RESET}, "ctrl_rst");
    rd(OFS_FRAME, 32'h0000_0000, "fb_rst");
    `CK("split_rst", 1'b0, x.split_oe)
  endtask
  task automatic t_frame;
    fr(1'b0, 1'b0, 7'h41);
    rd(OFS_FRAME, 32'h0000_c002, "fb_wr");
    rd(OFS_CONTROL, 32'h0000_0821, "ctrl_wr");
    `CK("split", 1'b1, x.split_oe)
    `CK("supply_keep", 1'b1, x.supply_on)
    fr(1'b0, 1'b1, 7'h00);
    rd(OFS_FRAME, 32'h0000_d821, "fb_ro");
    rd(OFS_CONTROL, 32'h0000_0821, "ctrl_ro");
    fr(1'b1, 1'b1, 7'h00);
    rd(OFS_FRAME, 32'h0000_fa5c, "fb_gp");
    host_u.xfer(1'b1, OFS_FRAME, 32'h0000_8000, q);
    rd(OFS_FRAME, 32'h0000_fa5c, "fb_sel");
    rd(4'hc, 32'h0000_0000, "unmapped");
  endtask
  task automatic t_link;
    fr(1'b0, 1'b0, 7'h02);
    `CK("supply_off", 1'b0, x.supply_on)
    pins.sys_mode_ok <= 1'b1;
    pins.bus_active <= 1'b1;
    wst(XCVR_ACTIVE);
    `CK("active", XCVR_ACTIVE, x.state)
    `CK("tx_on", 1'b1, x.tx_enable)
    pins.iface_fail <= 1'b1;
    settle;
    `CK("tx_fail", 1'b0, x.tx_enable)
    rd(OFS_CONTROL, 32'h0000_0041, "ctrl_fail");
    pins.iface_fail <= 1'b0;
    pins.iface_good_rx <= 1'b1;
    settle;
    `CK("tx_auto", 1'b1, x.tx_enable)
    pins.iface_good_rx <= 1'b0;
    pins.iface_fail <= 1'b1;
    settle;
    pins.iface_fail <= 1'b0;
    fr(1'b0, 1'b0, 7'h0e);
    `CK("tx_dis", 1'b0, x.tx_enable)
    pins.txd <= 1'b1;
    settle;
    `CK("loop_hi", 1'b1, x.rxd)
    pins.txd <= 1'b0;
    pins.bus_rxd <= 1'b1;
    settle;
    `CK("loop_lo", 1'b0, x.rxd)
    fr(1'b0, 1'b0, 7'h02);
    `CK("tx_manual", 1'b1, x.tx_enable)
    pins.txd <= 1'b1;
    pins.bus_rxd <= 1'b0;
    settle;
    `CK("no_loop", 1'b0, x.rxd)
  endtask
  task automatic t_listen;
    fr(1'b0, 1'b0, 7'h20);
    wst(XCVR_ONLINE);
    `CK("online", XCVR_ONLINE, x.state)
    rd(OFS_CONTROL, 32'h0000_0001, "listen_clr");
    pins.bus_active <= 1'b0;
    wst(XCVR_OFFLINE);
    `CK("off_idle", XCVR_OFFLINE, x.state)
    fr(1'b0, 1'b0, 7'h20);
    pins.bus_active <= 1'b1;
    wst(XCVR_LISTEN);
    `CK("listen", XCVR_LISTEN, x.state)
    pins.bus_active <= 1'b0;
    wst(XCVR_OFFLINE);
    `CK("off_listen", XCVR_OFFLINE, x.state)
  endtask
  // Idle spans are counted in cycles; one tick of slack covers the phase.
  task automatic t_timeout;
    int n;
    fr(1'b0, 1'b0, 7'h10);
    pins.bus_active <= 1'b1;
    wst(XCVR_ONLINE);
    pins.bus_active <= 1'b0;
    for (n = 0; n < 3000 && x.state !== XCVR_OFFLINE; n++) @(posedge clk_sys);
    `CK("tmo_long", 1'b1, n > 105 && n <= 160)
    pins.wake <= 1'b1;
    wst(XCVR_ONLINE);
    pins.wake <= 1'b0;
    rd(OFS_STATUS, 32'h0000_0015, "status_wake");
    for (n = 0; n < 3000 && x.state !== XCVR_OFFLINE; n++) @(posedge clk_sys);
    `CK("tmo_ext", 1'b1, n > 190 && n <= 260)
  endtask
  task automatic final_report;
    if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_reset;
    t_frame;
    t_link;
    t_listen;
    t_timeout;
    final_report;
  end
  // The whole run needs under a thousand cycles; this bound leaves ample room.
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    final_report;
  end
endmodule

/* verification/cpc_can_phy_control_register_sva.sv */
// Concurrent checks on the ports of the transceiver control register.
// Assumes one clock and a master that drops its request after each answer.
module cpc_can_phy_control_register_sva
  import cpc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire cpc_pkg::cpc_avs_req_t avs_req,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire logic [11:0] gp1_feedback,
  input wire cpc_pkg::cpc_pins_t pins,
  input wire cpc_pkg::cpc_xcvr_out_t xcvr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_wait_one_cycle: assert property (
    $rose(avs_req.read | avs_req.write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("Request not answered after one wait cycle.");
  a_frame_select: assert property (
    avs_req.read && !avs_waitrequest && avs_req.address == OFS_FRAME &&
    avs_readdata != 0 |-> avs_readdata[15:14] == SEL_CAN_PHY)
    else $error("Frame feedback shows a foreign select code.");
  a_tx_only_active: assert property (
    xcvr.tx_enable |-> xcvr.state == XCVR_ACTIVE)
    else $error("Transmitter enabled outside the active state.");
  a_split_on_write: assert property (
    $changed(xcvr.split_oe) |-> $past(avs_req.write))
    else $error("Split output changed without a write.");
  a_fail_blocks_tx: assert property (
    pins.iface_fail [*5] |-> !xcvr.tx_enable)
    else $error("Transmitter stays on during an interface failure.");
  a_idle_before_off: assert property (
    $changed(xcvr.state) && xcvr.state == XCVR_OFFLINE |->
    !$past(pins.bus_active, 3) && !$past(pins.bus_active, 40))
    else $error("Went off-line while the bus was busy.");
  a_active_needs_mode: assert property (
    xcvr.state == XCVR_ACTIVE |->
    $past(pins.sys_mode_ok, 3) || $past(pins.sys_mode_ok, 4))
    else $error("Active state outside normal or flash mode.");
  a_rx_follows_bus: assert property (
    xcvr.tx_enable && $past(xcvr.tx_enable) &&
    $past(pins.bus_rxd, 3) == $past(pins.bus_rxd, 4) |->
    xcvr.rxd == $past(pins.bus_rxd, 3))
    else $error("Receive output not following the bus.");
  c_active: cover property (xcvr.state == XCVR_ACTIVE);
  c_listen: cover property (xcvr.state == XCVR_LISTEN);
  c_loop: cover property (!xcvr.tx_enable && xcvr.rxd && !pins.bus_rxd);
endmodule

bind cpc_can_phy_control_register cpc_can_phy_control_register_sva sva_u (
  .clk_sys, .rstn, .avs_req, .avs_waitrequest, .avs_readdata, .gp1_feedback,
  .pins, .xcvr);

/* verification/cpc_host_model.sv */
// Avalon-MM master standing in for the host microcontroller.
// Assumes the slave answers by lowering waitrequest; drives at rising edges.
module cpc_host_model
  import cpc_pkg::*;
(
  input wire logic clk_sys,
  output cpc_pkg::cpc_avs_req_t avs_req,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial avs_req = '0;
  task automatic xfer(input logic w, input logic [3:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    avs_req <= '{a, !w, w, d, 4'hf};
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_req <= '0;
  endtask
  // Reserved bits always go out as the host owes them, 4..1 low, 0 high.
  task automatic frame(input logic readback_source_select, input logic ro,
                       input logic [6:0] cfg, output logic [31:0] q);
    xfer(1'b1, OFS_FRAME, {16'h0000, SEL_CAN_PHY, readback_source_select, ro, cfg, 5'h01}, q);
  endtask
endmodule
